// file: gdc_pkg.sv
// Constants and types shared by the gate driver controller modules
`default_nettype none
package gdc_pkg;
   localparam int CLK_NS = 5;
   localparam int SAFE_NS = 100;
   localparam int SAFE_CYC = (SAFE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_NS = 1000;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [8:0] SAFE_LOAD = 9'(SAFE_CYC - 1);
   localparam logic [8:0] PULSE_LOAD = 9'(PULSE_CYC - 1);

   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_CMD = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;

   localparam int CTRL_GATE_BIT = 0;
   localparam int CTRL_INV_BIT = 1;
   localparam int CTRL_EN_BIT = 2;
   localparam int CMD_RESET_BIT = 0;
   localparam int ST_SEEN_BIT = 0;
   localparam int ST_NOW_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_ON_BIT = 3;

   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAFE = 3'b010,
      ST_PULSE = 3'b100
   } gdc_rst_state_t;
endpackage : gdc_pkg
`default_nettype wire

// file: gdc_flt_if.sv
// Filtered trip report carried from the pin filter to the controller
`timescale 1ns/1ps
`default_nettype none
interface gdc_flt_if;
   logic fault_low;
   logic fault_edge;
   modport src (output fault_low, output fault_edge);
   modport dst (input fault_low, input fault_edge);
endinterface : gdc_flt_if
`default_nettype wire

// file: gdc_flt_sync.sv
// Three-stage filter for the open-collector trip report pin
`timescale 1ns/1ps
`default_nettype none
module gdc_flt_sync
   import gdc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic trip_report_b,
   gdc_flt_if.src flt
);
   logic s1, s2, s3;
   logic low, edge_q;
   logic next_low, next_edge;

   // A level change only counts once the second and third stages agree
   always_comb begin
      next_low = low;
      if (s2 == s3) begin
         next_low = ~s3;
      end
      next_edge = next_low & ~low;
   end

   // Released line idles high through the external pull-up
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         low <= 1'b0;
         edge_q <= 1'b0;
      end else begin
         s1 <= trip_report_b;
         s2 <= s1;
         s3 <= s2;
         low <= next_low;
         edge_q <= next_edge;
      end
   end

   assign flt.fault_low = low;
   assign flt.fault_edge = edge_q;
endmodule : gdc_flt_sync
`default_nettype wire

// file: gdc_top.sv
// Gate driver controller: AHB-Lite registers, gate pins, fault and reset
// Notes on behaviour
// RULE1 - Driver clamps its output low until output supply passes release level.
// RULE2 - Driver arms desaturation sensing before the lockout clamp lets go.
// RULE3 - Without fault, gate inputs steer emitter; trip line released; reset ignored.
// RULE4 - On fault, driver latches, pulls trip line low, forces emitter off.
// RULE5 - Driver keeps latched fault until its active-low reset is driven low.
// RULE6 - Received emitter sets output only with no fault and no lockout.
// RULE7 - Pull-up and pull-down enables are never on together.
// RULE8 - Under lockout the large pull-down holds the output low.
// RULE9 - Desaturation while on latches fault; only small pull-down stays enabled.
// RULE10 - Below two volts above negative rail, large pull-down clamps again.
// RULE11 - Output-side fault flag clears only once emitter state turns off.
// RULE12 - Active-low reset and open-collector trip line; far side pulls it up.
// RULE13 - Non-inverting use: inverting input held low, non-inverting input toggled.
// RULE14 - Inverting use: non-inverting input held high, inverting input toggled.
// RULE15 - Both gate inputs driven push-pull, never resistor pulled.
// RULE16 - Controller polls each trip line and resets each driver on its own.
// RULE17 - While reset is low, gate inputs command the output low.
// RULE18 - Collector sense above 7 V while on counts as desaturation.
// RULE19 - Emitter is non-inverting high and inverting low, blocked by fault.
// RULE20 - Driver conditions are comparator inputs; its latches need no clock.
`timescale 1ns/1ps
`default_nettype none
module gdc_top
   import gdc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic noninv_gate_in,
   output logic inv_gate_in,
   output logic driver_reset_b,
   input wire logic trip_report_b
);
   gdc_flt_if flt ();

   gdc_flt_sync u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .trip_report_b(trip_report_b),
      .flt(flt.src)
   );

   // Bus slave state
   logic dp_wr;
   logic [11:0] dp_addr;
   logic next_dp_wr;
   logic [11:0] next_dp_addr;
   logic [31:0] next_hrdata;
   logic addr_ok;

   // Register and sequencer state
   logic [2:0] ctrl;
   logic fault_seen;
   gdc_rst_state_t rstate;
   logic [8:0] cnt;
   logic [2:0] next_ctrl;
   logic next_seen;
   gdc_rst_state_t next_rstate;
   logic [8:0] next_cnt;
   logic next_noninv, next_inv, next_reset_b;
   logic cmd_on, wr_ctrl, wr_cmd, wr_status;

   assign addr_ok = hsel & htrans[1] & hready;
   assign wr_ctrl = dp_wr & (dp_addr == OFS_CTRL);
   assign wr_cmd = dp_wr & (dp_addr == OFS_CMD);
   assign wr_status = dp_wr & (dp_addr == OFS_STATUS);

   // Zero-wait slave: read data is prepared in the address phase
   always_comb begin
      next_dp_wr = addr_ok & hwrite;
      next_dp_addr = haddr[11:0];
      next_hrdata = DATA_ZERO;
      if (addr_ok && !hwrite) begin
         case (haddr[11:0])
            OFS_CTRL: begin
               next_hrdata = {29'h0000_0000, ctrl};
            end
            OFS_STATUS: begin
               next_hrdata[ST_SEEN_BIT] = fault_seen;
               next_hrdata[ST_NOW_BIT] = flt.fault_low;
               next_hrdata[ST_BUSY_BIT] = (rstate != ST_IDLE);
               next_hrdata[ST_ON_BIT] = noninv_gate_in & ~inv_gate_in;
            end
            default: begin
               next_hrdata = DATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dp_wr <= 1'b0;
         dp_addr <= 12'h000;
         hrdata <= DATA_ZERO;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_wr <= next_dp_wr;
         dp_addr <= next_dp_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Control, sticky fault, reset sequencer and pin drive
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = hwdata[2:0];
      end
      // A fault in the clearing cycle keeps the flag set
      next_seen = flt.fault_edge |
         (fault_seen & ~(wr_status & hwdata[ST_SEEN_BIT])); // RULE16
      next_rstate = rstate;
      next_cnt = cnt;
      case (rstate)
         ST_IDLE: begin
            if (wr_cmd && hwdata[CMD_RESET_BIT]) begin
               next_rstate = ST_SAFE;
               next_cnt = SAFE_LOAD;
            end
         end
         ST_SAFE: begin
            // Gate inputs settle to the off command before reset is asserted
            if (cnt == 9'h000) begin
               next_rstate = ST_PULSE;
               next_cnt = PULSE_LOAD;
            end else begin
               next_cnt = cnt - 9'h001;
            end
         end
         ST_PULSE: begin
            if (cnt == 9'h000) begin
               next_rstate = ST_IDLE;
            end else begin
               next_cnt = cnt - 9'h001;
            end
         end
         default: begin
            next_rstate = ST_IDLE;
            next_cnt = 9'h000;
         end
      endcase
      // Gate stays off while a fault is pending or a reset runs
      cmd_on = ctrl[CTRL_GATE_BIT] & ctrl[CTRL_EN_BIT] & ~flt.fault_low &
         ~fault_seen & (rstate == ST_IDLE); // RULE16 RULE17
      if (ctrl[CTRL_INV_BIT]) begin
         next_noninv = 1'b1; // RULE14
         next_inv = ~cmd_on; // RULE14
      end else begin
         next_noninv = cmd_on; // RULE13
         next_inv = 1'b0; // RULE13
      end
      next_reset_b = (next_rstate != ST_PULSE); // RULE12 RULE16
   end

   // Pins come from flops and are always driven both ways
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= CTRL_RESET;
         fault_seen <= 1'b0;
         rstate <= ST_IDLE;
         cnt <= 9'h000;
         noninv_gate_in <= 1'b0; // RULE15
         inv_gate_in <= 1'b0;
         driver_reset_b <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         fault_seen <= next_seen;
         rstate <= next_rstate;
         cnt <= next_cnt;
         noninv_gate_in <= next_noninv; // RULE15
         inv_gate_in <= next_inv;
         driver_reset_b <= next_reset_b;
      end
   end

   // Checking helper: length of each reset pulse
   logic [8:0] low_len;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         low_len <= 9'h000;
      end else begin
         low_len <= driver_reset_b ? 9'h000 : low_len + 9'h001;
      end
   end

   sequence s_pulse_start;
      $fell(driver_reset_b);
   endsequence

   sequence s_pulse_end;
      $rose(driver_reset_b);
   endsequence

   property p_safe_before_pulse;
      @(posedge mclk) disable iff (!rst_b)
         s_pulse_start |-> $past(rstate == ST_SAFE);
   endproperty

   a_reset_order: assert property (p_safe_before_pulse) // RULE12
      else $error("reset asserted without safe gate phase");

   a_pulse_len: assert property (@(posedge mclk) disable iff (!rst_b) // RULE16
      s_pulse_end |-> low_len == 9'(PULSE_CYC))
      else $error("reset pulse length wrong");

   a_noninv_mode: assert property (@(posedge mclk) disable iff (!rst_b) // RULE13
      !$past(ctrl[CTRL_INV_BIT]) |-> !inv_gate_in)
      else $error("inverting input not held low");

   a_inv_mode: assert property (@(posedge mclk) disable iff (!rst_b) // RULE14
      $past(ctrl[CTRL_INV_BIT]) |-> noninv_gate_in)
      else $error("non-inverting input not held high");

   a_reset_gate_low: assert property (@(posedge mclk) disable iff (!rst_b) // RULE17
      !driver_reset_b |-> (!noninv_gate_in || inv_gate_in))
      else $error("gate commanded on during reset");

   a_fault_gate_off: assert property (@(posedge mclk) disable iff (!rst_b) // RULE16
      flt.fault_low |=> (!noninv_gate_in || inv_gate_in))
      else $error("gate not commanded off after fault");

   a_fault_sticky: assert property (@(posedge mclk) disable iff (!rst_b) // RULE16
      flt.fault_edge |=> fault_seen)
      else $error("fault not recorded");

   a_safe_len: assert property (@(posedge mclk) disable iff (!rst_b) // RULE17
      $rose(rstate == ST_SAFE) |-> (rstate != ST_PULSE)[*8])
      else $error("safe phase too short");
endmodule : gdc_top
`default_nettype wire

// file: gdc_drv_model.sv
// Behavioural model of the isolated gate driver seen by the controller
`timescale 1ns/1ps
`default_nettype none
module gdc_drv_model (
   input wire logic noninv_gate_in,
   input wire logic inv_gate_in,
   input wire logic driver_reset_b,
   input wire logic supply_low_lockout,
   input wire logic desat_sense,
   output var logic gate_drive_out,
   output wire trip_report_b
);
   logic in_flt = 1'b0;
   logic out_flt = 1'b0;
   logic emit;
   logic pull_up;
   logic big_pd;
   logic small_pd;
   logic below_two;
   // Isolation delay keeps the fault loop from settling in zero time
   assign #1 emit = noninv_gate_in & ~inv_gate_in & ~in_flt;
   // Open collector: released means high impedance, never a driven one
   assign trip_report_b = in_flt ? 1'b0 : 1'bz;
   always @* begin
      if (!driver_reset_b) in_flt = 1'b0;
      else if (out_flt) in_flt = 1'b1;
   end
   // Sensing is armed even under lockout, ahead of the clamp release
   always @* begin
      if (!emit) out_flt = 1'b0;
      else if (desat_sense) out_flt = 1'b1;
   end
   assign pull_up = emit & ~out_flt & ~supply_low_lockout;
   // Small pull-down works alone while the collector fault is latched, until lockout or the low-output comparator enables the large one
   assign small_pd = out_flt & ~supply_low_lockout;
   // Output-low comparator lets the large pull-down clamp after soft discharge
   assign #1 below_two = ~gate_drive_out;
   assign big_pd = supply_low_lockout |
      (~pull_up & (~small_pd | below_two));
   always @* gate_drive_out = pull_up & ~big_pd & ~small_pd;
endmodule : gdc_drv_model
`default_nettype wire

// file: gdc_top_bench.sv
// Self-checking bench for the gate driver controller
`timescale 1ns/1ps
`default_nettype none
module gdc_top_bench;
   import gdc_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic lock = 1'b1;
   logic desat = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [31:0] rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   wire logic hreadyout, hresp, ninv, inv, drst_b, gout;
   wire logic [31:0] hrdata;
   wire trip_b;
   int miscompares = 0;
   int checks = 0;
   int n;
   pullup (trip_b);
   gdc_top dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .noninv_gate_in(ninv), .inv_gate_in(inv),
      .driver_reset_b(drst_b), .trip_report_b(trip_b));
   gdc_drv_model drv (.noninv_gate_in(ninv), .inv_gate_in(inv),
      .driver_reset_b(drst_b), .supply_low_lockout(lock),
      .desat_sense(desat), .gate_drive_out(gout), .trip_report_b(trip_b));
   initial forever #2.5 mclk = ~mclk;
   task test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task wt(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : wt
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0_0000, a};
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task t_reset;
      chk({hresp, ninv, inv, drst_b}, 4'h1);
      bus(1'b0, OFS_CTRL, DATA_ZERO, rd);
      chk(rd, DATA_ZERO);
      bus(1'b0, OFS_STATUS, DATA_ZERO, rd);
      chk(rd, DATA_ZERO);
      bus(1'b1, 12'h100, 32'hFFFF_FFFF, rd);
      bus(1'b0, 12'h100, DATA_ZERO, rd);
      chk(rd, DATA_ZERO);
   endtask : t_reset
   task t_modes;
      bus(1'b1, OFS_CTRL, 32'h0000_0005, rd);
      wt(3);
      chk({ninv, inv, gout}, 3'h4);
      lock <= 1'b0;
      wt(1);
      chk(gout, 1'b1);
      bus(1'b0, OFS_STATUS, DATA_ZERO, rd);
      chk(rd[ST_ON_BIT], 1'b1);
      bus(1'b1, OFS_CTRL, 32'h0000_0007, rd);
      wt(3);
      chk({ninv, inv, gout}, 3'h5);
      bus(1'b1, OFS_CTRL, 32'h0000_0006, rd);
      wt(3);
      chk({ninv, inv, gout}, 3'h6);
      bus(1'b1, OFS_CTRL, 32'h0000_0001, rd);
      wt(3);
      chk({ninv, inv}, 2'h0);
      bus(1'b1, OFS_CTRL, 32'h0000_0005, rd);
      wt(3);
   endtask : t_modes
   task t_fault;
      desat <= 1'b1;
      wt(8);
      chk({trip_b, ninv, inv, gout}, 4'h0);
      bus(1'b0, OFS_STATUS, DATA_ZERO, rd);
      chk(rd[3:0], 4'h3);
      desat <= 1'b0;
      wt(20);
      chk({trip_b, ninv}, 2'h0);
   endtask : t_fault
   task t_recover;
      bus(1'b1, OFS_CMD, 32'h0000_0001, rd);
      bus(1'b0, OFS_STATUS, DATA_ZERO, rd);
      chk(rd[ST_BUSY_BIT], 1'b1);
      bus(1'b0, OFS_CMD, DATA_ZERO, rd);
      chk(rd, DATA_ZERO);
      // A second start while busy must not stretch or repeat the pulse
      bus(1'b1, OFS_CMD, 32'h0000_0001, rd);
      n = 0;
      while (drst_b !== 1'b0 && n < 300) begin
         wt(1);
         n++;
      end
      n = 0;
      while (drst_b === 1'b0 && n < 300) begin
         chk({ninv, inv}, 2'h0);
         wt(1);
         n++;
      end
      chk(n, PULSE_CYC);
      chk(trip_b, 1'b1);
      wt(2);
      chk(ninv, 1'b0);
      bus(1'b1, OFS_STATUS, 32'h0000_0001, rd);
      wt(3);
      chk({ninv, inv, gout}, 3'h5);
      bus(1'b0, OFS_STATUS, DATA_ZERO, rd);
      chk(rd[2:0], 3'h0);
   endtask : t_recover
   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      wt(1);
      t_reset();
      t_modes();
      t_fault();
      t_recover();
      test_done();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      test_done();
   end
endmodule : gdc_top_bench
`default_nettype wire
